/* ipm_pkg.sv */
// package for the two-wire page-write / sequential-read master
// assumes a single clock domain; shared by the controller and its helpers
package ipm_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W     = 8;   // bits per bus byte
  localparam int unsigned DIV_W      = 16;  // width of the prescale value
  localparam int unsigned FIFO_DEPTH = 16;  // queued transmit writes

  // ----------------------------------------------------------------
  // queued command word layout
  // ----------------------------------------------------------------
  localparam int unsigned CMD_DATA_LSB  = 0;   // data byte, bits 7..0
  localparam int unsigned CMD_ENABLE    = 8;   // controller enable copy
  localparam int unsigned CMD_ACKOUT    = 9;   // acknowledge-out copy
  localparam int unsigned CMD_STOP      = 10;  // stop request copy
  localparam int unsigned CMD_START     = 11;  // start request copy
  localparam int unsigned CMD_W         = 12;  // whole command width

  // ----------------------------------------------------------------
  // address byte and bit counting
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_DIR_BIT  = 0;       // 1 = read, 0 = write
  localparam logic [3:0]  ACK_SLOT      = 4'h8;    // ninth clock of a byte

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        OP_COMPLETE_RST = 1'b1;  // idle after reset
  localparam logic        ACK_RX_RST      = 1'b0;
  localparam logic        BYTE_RX_RST     = 1'b0;
  localparam logic [7:0]  RX_DATA_RST     = 8'h00;
  localparam logic        PIN_LOW_LEVEL   = 1'b0;  // level driven when enabled

  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_BIT   = 4'b0100,
    ST_STOP  = 4'b1000
  } ipm_state_e;

endpackage

/* ipm_fifo.sv */
// synchronous fifo with registered output word and valid/ready both sides
// assumes one clock; capacity is DEPTH in memory plus one output word
module ipm_fifo
  import ipm_pkg::*;
#(
  parameter int unsigned WIDTH = CMD_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];   // queued words
  logic [PW-1:0]    wr_ptr_r;      // next slot to fill
  logic [PW-1:0]    rd_ptr_r;      // oldest stored word
  logic [CW-1:0]    cnt_r;         // words held in memory
  logic             out_valid_r;   // output word present
  logic [WIDTH-1:0] out_data_r;    // output word
  logic             push;          // word accepted
  logic             load;          // memory word moves to output

  assign in_ready  = (cnt_r != FULL_CNT);
  assign push      = in_valid && in_ready;
  assign load      = (cnt_r != '0) && (!out_valid_r || out_ready);
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  // memory write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (load) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !load) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (load && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // registered output word
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (load) begin
      out_valid_r <= 1'b1;
      out_data_r  <= mem[rd_ptr_r];
    end else if (out_ready) begin
      out_valid_r <= 1'b0;
    end
  end

endmodule

/* ipm_tick.sv */
// half-period enable for the bus clock: one pulse every div+1 cycles
// assumes div is steady while run is high
module ipm_tick
  import ipm_pkg::*;
#(
  parameter int unsigned W = DIV_W
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] div,
  // enable out
  output logic              tick
);

  logic [W-1:0] cnt_r;   // cycles since last pulse
  logic         tick_r;  // registered pulse

  assign tick = tick_r;

  // counter restarts whenever the engine is idle so phases align
  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == div) begin
      cnt_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

endmodule

/* ipm_ctrl.sv */
// two-wire bus master: start, address, page write, sequential read, stop
// assumes control bits and transmit writes come from logic on ref_clk;
// bus pins are open drain and resolved outside, inputs are asynchronous

// How it works
// - page write sends bytes until stop requested
// - start plus enable then address write
// - transmit write clears completion flag
// - completion set after address, ack reported
// - each further write sends one data byte
// - stop plus enable with dummy write
// - finished stop releases bus ownership
// - repeated start with read direction bit
// - dummy write clocks one byte in
// - byte received flag set per byte
// - acknowledge-out drives ack after byte
// - clear acknowledge-out to end read
// - bus clock is clock/(prescale+1)/2
// - single byte read unacknowledged, then stop
module ipm_ctrl
  import ipm_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // control bits
  input  wire logic             controller_enable_bit,
  input  wire logic             start_request_bit,
  input  wire logic             stop_request_bit,
  input  wire logic             ack_out_bit,
  input  wire logic [DIV_W-1:0] bus_clock_divider,
  // transmit data register write
  input  wire logic             tx_wr_valid,
  input  wire logic [7:0]       tx_wr_data,
  output logic                  tx_wr_ready,
  // receive data register
  input  wire logic             rx_rd,
  output logic [7:0]            rx_data,
  // status bits
  output logic                  op_complete_flag,
  output logic                  ack_received_flag,
  output logic                  byte_received_flag,
  output logic                  bus_owned,
  // clock pin
  input  wire logic             scl_in,
  output logic                  scl_out,
  output logic                  scl_oe,
  // data pin
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ipm_state_e        state_r;       // engine state
  logic [1:0]        ph_r;          // half-period phase inside a state
  logic [3:0]        bit_cnt_r;     // bit index, ACK_SLOT is the ack clock
  logic [7:0]        shift_r;       // outgoing / incoming byte
  logic [CMD_W-1:0]  cmd_r;         // command being executed
  logic              xmit_r;        // this byte is sent by the master
  logic              dir_rd_r;      // last address asked for a read
  logic              owned_r;       // master holds the bus
  logic              scl_oe_r;      // pulling the clock low
  logic              sda_oe_r;      // pulling the data low
  logic [7:0]        rx_data_r;     // last received byte
  logic              op_cmpl_r;     // operation complete
  logic              ack_rx_r;      // slave acknowledged
  logic              byte_rx_r;     // a byte waits in rx_data
  logic [1:0]        scl_sync_r;    // clock pin synchroniser
  logic [1:0]        sda_sync_r;    // data pin synchroniser
  logic              scl_s;         // synchronised clock level
  logic              sda_s;         // synchronised data level
  logic              tick;          // half bus-clock period enable
  logic              q_valid;       // queued command present
  logic [CMD_W-1:0]  q_data;        // queued command
  logic              q_take;        // engine takes queued command
  logic              tx_push;       // transmit write accepted
  logic              done;          // command finished this cycle
  logic              cmpl_pend_r;   // a finish waits for the queue to dry
  logic              byte_done;     // received byte finished this cycle
  logic [CMD_W-1:0]  tx_word;       // write packed with control bits

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops each; only the second stage is read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
    end
  end

  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];

  // ----------------------------------------------------------------
  // transmit queue
  // ----------------------------------------------------------------
  // control bits are captured with each write, so software may change
  // them for the next byte while the current one is still on the wire
  assign tx_word = {start_request_bit, stop_request_bit, ack_out_bit,
                    controller_enable_bit, tx_wr_data};
  assign tx_push = tx_wr_valid && tx_wr_ready;
  assign q_take  = (state_r == ST_IDLE) && q_valid;

  ipm_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (tx_wr_valid),
    .in_data   (tx_word),
    .in_ready  (tx_wr_ready),
    .out_valid (q_valid),
    .out_data  (q_data),
    .out_ready (q_take)
  );

  // ----------------------------------------------------------------
  // bus clock divider
  // ----------------------------------------------------------------
  // one tick per half period, two half periods per bus clock
  ipm_tick #(
    .W (DIV_W)
  ) u_tick (
    .ref_clk (ref_clk),
    .reset   (reset),
    .run     (state_r != ST_IDLE),
    .div     (bus_clock_divider),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // engine
  // ----------------------------------------------------------------
  // done pulses end a command; byte_done marks a received byte
  always_comb begin
    done      = 1'b0;
    byte_done = 1'b0;
    if (q_take) begin
      // disabled, or nothing to do on a bus that is not held
      done = !q_data[CMD_ENABLE] ||
             (!q_data[CMD_START] && !owned_r);
    end else if (tick && ph_r == 2'd1 && scl_s) begin
      if (state_r == ST_BIT && bit_cnt_r == ACK_SLOT) begin
        done      = 1'b1;
        byte_done = !xmit_r;
      end else if (state_r == ST_STOP) begin
        done = 1'b1;
      end
    end
  end

  // state, phase and bit sequencing
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r   <= ST_IDLE;
      ph_r      <= 2'd0;
      bit_cnt_r <= 4'h0;
      cmd_r     <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          ph_r      <= 2'd0;
          bit_cnt_r <= 4'h0;
          if (q_take) begin
            cmd_r <= q_data;
            if (!q_data[CMD_ENABLE]) begin
              state_r <= ST_IDLE;            // dropped, reported complete
            end else if (q_data[CMD_START]) begin
              state_r <= ST_START;
            end else if (!owned_r) begin
              state_r <= ST_IDLE;            // no bus held, nothing sent
            end else if (q_data[CMD_STOP]) begin
              state_r <= ST_STOP;
            end else begin
              state_r <= ST_BIT;
            end
          end
        end
        ST_START: begin
          // release data, raise clock, drop data, drop clock
          if (tick && (ph_r != 2'd1 || scl_s)) begin
            if (ph_r == 2'd2) begin
              ph_r    <= 2'd0;
              state_r <= ST_BIT;             // address byte follows
            end else begin
              ph_r <= ph_r + 2'd1;
            end
          end
        end
        ST_BIT: begin
          // phase 0 clock low, phase 1 clock high (waits for stretch)
          if (tick && ph_r == 2'd0) begin
            ph_r <= 2'd1;
          end else if (tick && ph_r == 2'd1 && scl_s) begin
            ph_r <= 2'd0;
            if (bit_cnt_r == ACK_SLOT) begin
              state_r <= ST_IDLE;
            end else begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_STOP: begin
          // raise clock with data low, then release data
          if (tick && ph_r == 2'd0) begin
            ph_r <= 2'd1;
          end else if (done) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // byte shifter and direction tracking
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_r  <= 8'h00;
      xmit_r   <= 1'b0;
      dir_rd_r <= 1'b0;
    end else if (q_take) begin
      shift_r <= q_data[CMD_DATA_LSB +: BYTE_W];
      // address after start always goes out; later bytes follow direction
      xmit_r  <= q_data[CMD_START] || !dir_rd_r;
      if (q_data[CMD_START] && q_data[CMD_ENABLE]) begin
        dir_rd_r <= q_data[CMD_DATA_LSB + ADDR_DIR_BIT];
      end
    end else if (state_r == ST_BIT && tick && ph_r == 2'd1 && scl_s &&
                 bit_cnt_r != ACK_SLOT) begin
      // msb out, sampled bit in; for a sent byte the input is ignored
      shift_r <= {shift_r[6:0], sda_s};
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // data changes one clock after the clock falls; only start and stop move it while the clock is high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        ST_START: begin
          if (ph_r == 2'd0) begin
            sda_oe_r <= 1'b0;                   // release for repeated start
            if (tick) begin
              scl_oe_r <= 1'b0;
            end
          end else if (ph_r == 2'd1 && tick && scl_s) begin
            sda_oe_r <= 1'b1;                   // falling data
          end else if (ph_r == 2'd2 && tick) begin
            scl_oe_r <= 1'b1;
          end
        end
        ST_BIT: begin
          if (ph_r == 2'd0) begin
            if (bit_cnt_r != ACK_SLOT) begin
              sda_oe_r <= xmit_r && !shift_r[7];
            end else begin
              // ack clock: listen when sending, answer when receiving
              sda_oe_r <= !xmit_r && cmd_r[CMD_ACKOUT];
            end
            if (tick) begin
              scl_oe_r <= 1'b0;
            end
          end else if (tick && scl_s) begin
            scl_oe_r <= 1'b1;
          end
        end
        ST_STOP: begin
          if (ph_r == 2'd0) begin
            sda_oe_r <= 1'b1;                   // data low under low clock
            if (tick) begin
              scl_oe_r <= 1'b0;
            end
          end else if (done) begin
            sda_oe_r <= 1'b0;                   // rising data
          end
        end
        ST_IDLE: begin
          // clock stays held low between bytes while the bus is ours
          if (!owned_r) begin
            sda_oe_r <= 1'b0;
          end else if (scl_oe_r) begin
            sda_oe_r <= 1'b0;
          end
        end
        default: begin
          scl_oe_r <= 1'b0;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // bus ownership
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      owned_r <= 1'b0;
    end else if (state_r == ST_START && ph_r == 2'd1 && tick && scl_s) begin
      owned_r <= 1'b1;
    end else if (state_r == ST_STOP && done) begin
      owned_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // completion: a finish that meets a fresh write is not reported; set
  // only when nothing else is queued
  // a dropped write is taken with q_valid high, so judge the queue a cycle on
  always_ff @(posedge ref_clk) begin
    if (reset || tx_push) begin
      cmpl_pend_r <= 1'b0;
    end else if (done || q_take) begin
      cmpl_pend_r <= done;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      op_cmpl_r <= OP_COMPLETE_RST;
    end else if (cmpl_pend_r && !q_valid && !tx_push) begin
      op_cmpl_r <= 1'b1;
    end else if (tx_push) begin
      op_cmpl_r <= 1'b0;
    end
  end

  // acknowledge seen on the ninth clock of a sent byte
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_rx_r <= ACK_RX_RST;
    end else if (state_r == ST_BIT && xmit_r && bit_cnt_r == ACK_SLOT &&
                 tick && ph_r == 2'd1 && scl_s) begin
      ack_rx_r <= !sda_s;
    end
  end

  // received byte and its flag; a new byte wins over a read clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_data_r <= RX_DATA_RST;
      byte_rx_r <= BYTE_RX_RST;
    end else if (byte_done) begin
      rx_data_r <= shift_r;
      byte_rx_r <= 1'b1;
    end else if (rx_rd) begin
      byte_rx_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rx_data            = rx_data_r;
  assign op_complete_flag   = op_cmpl_r;
  assign ack_received_flag  = ack_rx_r;
  assign byte_received_flag = byte_rx_r;
  assign bus_owned          = owned_r;
  assign scl_oe             = scl_oe_r;
  assign sda_oe             = sda_oe_r;
  assign scl_out            = PIN_LOW_LEVEL;
  assign sda_out            = PIN_LOW_LEVEL;

endmodule

/* ipm_asserts.sv */
// checker for the two-wire master, sees only the ipm_ctrl ports
// assumes one clock domain and a synchronous active high reset
module ipm_asserts
  import ipm_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             reset,
  // control bits
  input wire logic             controller_enable_bit,
  input wire logic             start_request_bit,
  input wire logic             stop_request_bit,
  input wire logic             ack_out_bit,
  input wire logic [DIV_W-1:0] bus_clock_divider,
  // transmit and receive
  input wire logic             tx_wr_valid,
  input wire logic [7:0]       tx_wr_data,
  input wire logic             tx_wr_ready,
  input wire logic             rx_rd,
  input wire logic [7:0]       rx_data,
  // status
  input wire logic             op_complete_flag,
  input wire logic             ack_received_flag,
  input wire logic             byte_received_flag,
  input wire logic             bus_owned,
  // pins
  input wire logic             scl_in,
  input wire logic             scl_out,
  input wire logic             scl_oe,
  input wire logic             sda_in,
  input wire logic             sda_out,
  input wire logic             sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [DIV_W:0] half_r;  // cycles since scl_oe last moved
  // stretching only lengthens a phase, so a floor is safe
  always_ff @(posedge ref_clk) begin
    if (reset || $changed(scl_oe)) half_r <= '0;
    else if (!(&half_r)) half_r <= half_r + 1'b1;
  end
  half_period_a: assert property ($changed(scl_oe) |-> half_r >= bus_clock_divider)
    else $error("bus clock phase shorter than prescale plus one");
  wr_clears_done_a: assert property (tx_wr_valid && tx_wr_ready |-> ##[1:2] !op_complete_flag)
    else $error("completion flag not cleared by a transmit write");
  done_not_pushed_a: assert property ($rose(op_complete_flag) |-> !$past(tx_wr_valid))
    else $error("completion raised over a fresh write");
  idle_pins_free_a: assert property (!bus_owned |-> !sda_oe && !scl_oe)
    else $error("pin pulled while the bus is not owned");
  start_cond_a: assert property ($rose(bus_owned) |-> sda_oe && !scl_oe && !$past(sda_oe))
    else $error("start not a data fall with the clock high");
  stop_cond_a: assert property ($fell(bus_owned) |-> $past(sda_oe) && !$past(scl_oe))
    else $error("stop not a data rise with the clock high");
  byte_flag_holds_a: assert property (byte_received_flag && !rx_rd |=> byte_received_flag)
    else $error("byte flag dropped without a read");
  rx_needs_flag_a: assert property ($changed(rx_data) |-> byte_received_flag)
    else $error("receive data changed without the byte flag");
  reset_state_a: assert property ($fell(reset) |-> op_complete_flag && !bus_owned)
    else $error("controller not idle after reset");
endmodule

/* ipm_eeprom.sv */
// behavioural serial eeprom slave on the two-wire bus
// assumes resolved open-drain lines with pull-ups in the bench
module ipm_eeprom #(
  parameter logic [6:0] DEV = 7'h50
) (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  // pacing request from the bench
  input wire logic slow,
  // pull-downs and the last master ack bit, 0 = ack
  output logic     pull,
  output logic     hold,
  output logic     mack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];  // storage array
  logic [7:0] sr;         // incoming byte
  logic [7:0] ptr;        // word address
  int         cnt;        // clock index in byte
  int         nb;         // bytes since start
  logic       rd;         // read direction
  logic       act;        // selected
  logic       prog;       // programming begun
  initial begin
    pull = 0; hold = 0; act = 0; mack = 1; ptr = 0; prog = 0; rd = 0;
    foreach (mem[i]) mem[i] = ~8'(i);
  end
  // start resets byte framing
  always @(negedge sda) if (scl) begin
    act = 1; rd = 0; cnt = 0; nb = 0;
  end
  // stop releases the line and, after a write with data bytes, begins programming
  always @(posedge sda) if (scl) begin
    act = 0; pull = 0; prog = !rd && nb > 2;
  end
  // sample data or the master ack on the rising clock
  always @(posedge scl) if (act) begin
    if (cnt < 8) sr = {sr[6:0], sda};
    else if (rd && !pull) begin
      mack = sda;
      ptr = ptr + 8'h01;
      if (sda) act = 0;
    end
    cnt = cnt + 1;
  end
  // drive ack or read data while the clock is low
  always @(negedge scl) if (act) begin
    pull = 0;
    if (cnt == 9) cnt = 0;
    if (cnt == 8 && !rd) begin
      if (nb == 0 && sr[7:1] != DEV) act = 0;
      else begin
        if (nb == 0) rd = sr[0];
        else if (nb == 1) ptr = sr;
        else begin mem[ptr] = sr; ptr = ptr + 8'h01; end
        pull = 1; nb = nb + 1;
      end
    end else if (rd && cnt < 8) pull = !mem[ptr][7 - cnt];
  end
  // slow answer: stretch the low phase
  always @(negedge scl) if (slow && act) begin
    hold = 1; #100 hold = 0;
  end
endmodule

/* tb_top.sv */
// self-checking bench: master, eeprom model and checker
// assumes ipm_pkg and the design files compile first
module tb_top
  import ipm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEVA = 7'h50;
  localparam logic [3:0] EN = 4'h8, ST = 4'h4, SP = 4'h2, AO = 4'h1;
  logic ref_clk = 0, reset = 1, en = 0, st = 0, sp = 0, ao = 0, v = 0, rx_rd = 0, slow = 0;
  logic [7:0] d = 8'h00, rxd;
  logic rdy, done, ackf, bytf, own, scl_oe, sda_oe, pull, hold, mack;
  wire scl = !(scl_oe | hold);  // pulled up
  wire sda = !(sda_oe | pull);  // pulled up
  int bad_count = 0, tests_run = 0;
  always #2 ref_clk = !ref_clk;
  ipm_ctrl dut (.ref_clk(ref_clk), .reset(reset), .controller_enable_bit(en),
    .start_request_bit(st), .stop_request_bit(sp), .ack_out_bit(ao),
    .bus_clock_divider(16'h0002), .tx_wr_valid(v), .tx_wr_data(d), .tx_wr_ready(rdy),
    .rx_rd(rx_rd), .rx_data(rxd), .op_complete_flag(done), .ack_received_flag(ackf),
    .byte_received_flag(bytf), .bus_owned(own), .scl_in(scl), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
  ipm_eeprom slave (.scl(scl), .sda(sda), .slow(slow), .pull(pull), .hold(hold), .mack(mack));
  task automatic close_out;
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic wait_done;
    for (int i = 0; i < 5000 && done !== 1'b1; i++) @(posedge ref_clk) #1;
    chk("op_complete_flag", 1, done);
    if (done !== 1'b1) close_out();
  endtask
  task automatic wr(input logic [3:0] c, input logic [7:0] b);
    @(posedge ref_clk);
    {en, st, sp, ao} <= c;
    d <= b;
    v <= 1;
    @(posedge ref_clk) v <= 0;
    @(posedge ref_clk) #1;
    chk("op_complete_flag", 0, done);
    wait_done();
  endtask
  task automatic pulse_rd;
    @(posedge ref_clk) rx_rd <= 1;
    @(posedge ref_clk) rx_rd <= 0;
    @(posedge ref_clk) #1;
  endtask
  task automatic t_page;
    wr(EN | ST, {DEVA, 1'b0});
    chk("ack_received_flag", 1, ackf);
    wr(EN, 8'h10);
    for (int i = 0; i < 4; i++) begin
      wr(EN, 8'hC0 + 8'(i));
      chk("ack_received_flag", 1, ackf);
    end
    wr(EN | SP, 8'h00);
    chk("bus_owned", 0, own);
    chk("programming", 1, slave.prog);
    for (int i = 0; i < 4; i++) chk("slave byte", 8'hC0 + 8'(i), slave.mem[16 + i]);
  endtask
  task automatic t_seq;
    wr(EN | ST, {DEVA, 1'b0});
    wr(EN, 8'h10);
    wr(EN | ST | AO, {DEVA, 1'b1});
    chk("ack_received_flag", 1, ackf);
    for (int i = 0; i < 3; i++) begin
      wr(i < 2 ? EN | AO : EN, 8'hFF);
      chk("byte_received_flag", 1, bytf);
      chk("rx_data", 8'hC0 + 8'(i), rxd);
      chk("master ack bit", i == 2, mack);
      pulse_rd();
      chk("byte_received_flag", 0, bytf);
    end
    wr(EN | SP, 8'h00);
    chk("bus_owned", 0, own);
  endtask
  task automatic t_single;
    wr(EN | ST, {DEVA, 1'b1});
    wr(EN, 8'hFF);
    chk("rx_data", 8'hC3, rxd);
    chk("master ack bit", 1, mack);
    wr(EN | SP, 8'h00);
    chk("bus_owned", 0, own);
  endtask
  task automatic t_nack;
    wr(EN | ST, {DEVA ^ 7'h01, 1'b0});
    chk("ack_received_flag", 0, ackf);
    wr(EN | SP, 8'h00);
    chk("bus_owned", 0, own);
  endtask
  // flood the queue behind a start byte while the slave stalls
  task automatic t_fill;
    int refused;
    refused = 0;
    @(posedge ref_clk);
    {en, st, sp, ao} <= EN | ST;
    {slow, v, d} <= {1'b1, 1'b1, DEVA, 1'b0};
    @(posedge ref_clk) {en, st} <= 2'b00;
    repeat (24) begin
      @(posedge ref_clk) #1;
      if (rdy !== 1'b1) refused++;
    end
    @(posedge ref_clk) v <= 0;
    chk("queue refusals", 1, refused > 0);
    wait_done();
    wr(EN | SP, 8'h00);
    chk("bus_owned", 0, own);
    slow <= 0;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk) #1;
    chk("op_complete_flag", 1, done);
    chk("byte_received_flag", 0, bytf);
    t_page();
    t_seq();
    t_single();
    t_nack();
    t_fill();
    close_out();
  end
endmodule

bind ipm_ctrl ipm_asserts #(.DEPTH(DEPTH)) chk_i (.*);
